// file: hw/dbgss_top.sv
// Debug step control, control and status register and data breakpoint of the processor debug module
//
// How it works
// - Control bit 10 set lets user code halt; clear keeps halt supervisor only.
// - Bits 9-8 pick trace branch-target bytes: none, two, three or four.
// - Bit 6 runs non-pipelined, no folding, at least five extra cycles each.
// - A triggered PC breakpoint always halts before its instruction executes.
// - Pipelined mode may report address and data triggers after later instructions.
// - Non-pipelined mode reports data triggers before the next instruction starts.
// - Bit 5 set masks pending interrupts during single-step; clear lets them through.
// - Bit 4 set halts after every instruction; clear runs normally.
// - While step-halted all commands work; each resume runs exactly one instruction.
// - A 32-bit data value is compared with local bus data for a trigger.
// - Set mask bits exclude positions from the compare; clear bits include them.
// - Byte operands come from the lane chosen by address bits 1:0.
// - Words use D[31:16] or D[15:0] by address bit 1; longwords use all.
// - A flag shows a breakpoint halt; reset or resume clears it.
// - Breakpoint triggers only fire while the global trigger enable is set.
`timescale 1ns/1ps
module dbgss_top
    import dbgss_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Debug command side
    input  wire logic        cmdWrite,
    input  wire logic        cmdRead,
    input  wire logic [1:0]  cmdSel,
    input  wire logic [31:0] cmdWdata,
    input  wire logic        cmdGo,
    output logic      [31:0] cmdRdata,
    // Trigger definition enable
    input  wire logic        triggerGlobalEnable,
    // Core pipeline side
    input  wire logic        instrStart,
    input  wire logic        instrRetire,
    input  wire logic        haltExec,
    input  wire logic        userMode,
    input  wire logic        pcBreakHit,
    // Local data bus
    input  wire logic        busValid,
    input  wire logic [1:0]  busAddr,
    input  wire logic [1:0]  busSize,
    input  wire logic [31:0] busData,
    // Controls and status toward the core
    output logic             issueOk,
    output logic             coreHalted,
    output logic             nonpipelinedSelect,
    output logic             foldDisable,
    output logic             irqIgnore,
    output logic             userHaltPermit,
    output logic             haltRefused,
    output logic      [2:0]  traceByteCount,
    output logic             dataTrigger,
    output logic             hwTriggerHaltFlag
);
    typedef struct packed {
        dbgss_mode_e mode;
        logic        stepIssued;
        logic        inFlight;
        logic [2:0]  gapCount;
        logic        halted;

        logic        userHaltPermit;
        logic [1:0]  branchTargetByteCount;
        logic        nonpipelinedSelect;
        logic        ignorePendingIrq;
        logic        singleStepSelect;

        logic [31:0] dataMatchValue;
        logic [31:0] dataMatchMask;

        logic        hwTriggerHaltFlag;
        logic        dataTrigger;
        logic        issueOk;
        logic        irqIgnore;
        logic        haltRefused;
        logic [2:0]  traceByteCount;
        logic [31:0] rdata;
    } dbgss_state_s;

    dbgss_state_s cur;
    dbgss_state_s nxt;

    dbgss_cmp_if cmpBus ();

    logic dataHit;
    logic pcHitOn;
    logic haltOk;
    logic trigHalt;

    assign cmpBus.matchValue = cur.dataMatchValue;
    assign cmpBus.matchMask  = cur.dataMatchMask;
    assign cmpBus.busData    = busData;
    assign cmpBus.busAddr    = busAddr;
    assign cmpBus.busSize    = busSize;

    dbgss_data_cmp uCmp (
        .cmpBus (cmpBus.cmp)
    );

    // Map the two-bit code to a byte count
    function automatic logic [2:0] traceBytes(input logic [1:0] code);
        case (code)
            2'h0: begin
                traceBytes = DBGSS_TRACE_NONE;
            end
            2'h1: begin
                traceBytes = DBGSS_TRACE_TWO;
            end
            2'h2: begin
                traceBytes = DBGSS_TRACE_THREE;
            end
            default: begin
                traceBytes = DBGSS_TRACE_FOUR;
            end
        endcase
    endfunction : traceBytes

    // Build the readable control and status word
    function automatic logic [31:0] ctrlImage(input dbgss_state_s s);
        logic [31:0] w;

        w                   = DBGSS_RST_WORD;
        w[DBGSS_BIT_FLAG]   = s.hwTriggerHaltFlag;
        w[DBGSS_BIT_UHALT]  = s.userHaltPermit;
        w[DBGSS_BIT_BTBH]   = s.branchTargetByteCount[1];
        w[DBGSS_BIT_BTBL]   = s.branchTargetByteCount[0];
        w[DBGSS_BIT_NOPIPE] = s.nonpipelinedSelect;
        w[DBGSS_BIT_IRQOFF] = s.ignorePendingIrq;
        w[DBGSS_BIT_STEP]   = s.singleStepSelect;
        return w;
    endfunction : ctrlImage

    always_comb begin
        nxt = cur;

        // Register writes are accepted in every mode
        if (cmdWrite) begin
            case (cmdSel)
                DBGSS_SEL_CTRL: begin
                    nxt.userHaltPermit        = cmdWdata[DBGSS_BIT_UHALT];
                    nxt.branchTargetByteCount = cmdWdata[DBGSS_BIT_BTBH:DBGSS_BIT_BTBL];
                    nxt.nonpipelinedSelect    = cmdWdata[DBGSS_BIT_NOPIPE];
                    nxt.ignorePendingIrq      = cmdWdata[DBGSS_BIT_IRQOFF];
                    nxt.singleStepSelect      = cmdWdata[DBGSS_BIT_STEP];
                end
                DBGSS_SEL_VALUE: begin
                    nxt.dataMatchValue = cmdWdata;
                end
                DBGSS_SEL_MASK: begin
                    nxt.dataMatchMask = cmdWdata;
                end
                default: begin
                end
            endcase
        end

        // Register reads, unused selects read as zero
        if (cmdRead) begin
            case (cmdSel)
                DBGSS_SEL_CTRL: begin
                    nxt.rdata = ctrlImage(cur);
                end
                DBGSS_SEL_VALUE: begin
                    nxt.rdata = cur.dataMatchValue;
                end
                DBGSS_SEL_MASK: begin
                    nxt.rdata = cur.dataMatchMask;
                end
                default: begin
                    nxt.rdata = DBGSS_RST_WORD;
                end
            endcase
        end

        // Data compare is registered; in pipelined mode later instructions may already be running
        nxt.dataTrigger = busValid && triggerGlobalEnable && dataHit;

        // Halt instruction privilege check
        nxt.haltRefused = haltExec && userMode && !cur.userHaltPermit;

        // Instruction tracking for non-pipelined operation
        if (instrStart) begin
            nxt.inFlight = 1'b1;
        end else if (instrRetire) begin
            nxt.inFlight = 1'b0;
        end
        if (instrRetire && cur.nonpipelinedSelect) begin
            nxt.gapCount = DBGSS_GAP_CYCLES;
        end else if (cur.gapCount != 3'h0) begin
            nxt.gapCount = cur.gapCount - 3'h1;
        end

        // Mode sequencing
        case (cur.mode)
            DBGSS_RUN: begin
                if (trigHalt) begin
                    nxt.mode = DBGSS_HALTED;
                end else if (haltOk) begin
                    nxt.mode = DBGSS_HALTED;
                end else if (cur.singleStepSelect && instrRetire) begin
                    nxt.mode = DBGSS_HALTED;
                end
            end
            DBGSS_STEP: begin
                if (instrStart) begin
                    nxt.stepIssued = 1'b1;
                end
                if (trigHalt || haltOk || (instrRetire && (cur.stepIssued || instrStart))) begin
                    nxt.mode = DBGSS_HALTED;
                end
            end
            DBGSS_HALTED: begin
                if (cmdGo) begin
                    nxt.stepIssued = 1'b0;
                    if (cur.singleStepSelect) begin
                        nxt.mode = DBGSS_STEP;
                    end else begin
                        nxt.mode = DBGSS_RUN;
                    end
                end
            end

            default: begin
                nxt.mode = DBGSS_HALTED;
            end
        endcase

        // Breakpoint halt flag, a trigger is ignored while halted so the resume clear wins
        if (trigHalt) begin
            nxt.hwTriggerHaltFlag = 1'b1;
        end else if (cmdGo && cur.mode == DBGSS_HALTED) begin
            nxt.hwTriggerHaltFlag = 1'b0;
        end

        // Issue permission for the next instruction
        nxt.issueOk = 1'b0;
        if (nxt.mode == DBGSS_RUN ||
            (nxt.mode == DBGSS_STEP && !nxt.stepIssued && !instrStart)) begin
            nxt.issueOk = 1'b1;
        end
        if (pcHitOn) begin
            nxt.issueOk = 1'b0;
        end
        if (nxt.nonpipelinedSelect &&
            (nxt.inFlight || instrRetire || nxt.gapCount != 3'h0)) begin
            nxt.issueOk = 1'b0;
        end

        // Registered controls toward the core and the trace unit
        nxt.irqIgnore      = nxt.singleStepSelect && nxt.ignorePendingIrq;
        nxt.traceByteCount = traceBytes(nxt.branchTargetByteCount);

        // Halted state kept in its own flop for the port
        nxt.halted         = (nxt.mode == DBGSS_HALTED);
    end

    assign dataHit  = cmpBus.hit;
    assign pcHitOn  = pcBreakHit && triggerGlobalEnable;
    assign haltOk   = haltExec && (!userMode || cur.userHaltPermit);
    assign trigHalt = (cur.mode != DBGSS_HALTED) && (cur.dataTrigger || pcHitOn);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur.mode                  <= DBGSS_RUN;
            cur.stepIssued            <= DBGSS_RST_BIT;
            cur.inFlight              <= DBGSS_RST_BIT;
            cur.gapCount              <= 3'h0;
            cur.halted                <= DBGSS_RST_BIT;
            cur.userHaltPermit        <= DBGSS_RST_BIT;
            cur.branchTargetByteCount <= DBGSS_RST_BTB;
            cur.nonpipelinedSelect    <= DBGSS_RST_BIT;
            cur.ignorePendingIrq      <= DBGSS_RST_BIT;
            cur.singleStepSelect      <= DBGSS_RST_BIT;
            cur.dataMatchValue        <= DBGSS_RST_WORD;
            cur.dataMatchMask         <= DBGSS_RST_WORD;
            cur.hwTriggerHaltFlag     <= DBGSS_RST_BIT;
            cur.dataTrigger           <= DBGSS_RST_BIT;
            cur.issueOk               <= DBGSS_RST_BIT;
            cur.irqIgnore             <= DBGSS_RST_BIT;
            cur.haltRefused           <= DBGSS_RST_BIT;
            cur.traceByteCount        <= DBGSS_TRACE_NONE;
            cur.rdata                 <= DBGSS_RST_WORD;
        end else begin
            cur <= nxt;
        end
    end

    assign cmdRdata           = cur.rdata;
    assign issueOk            = cur.issueOk;
    assign coreHalted         = cur.halted;
    assign nonpipelinedSelect = cur.nonpipelinedSelect;
    assign foldDisable        = cur.nonpipelinedSelect;
    assign irqIgnore          = cur.irqIgnore;
    assign userHaltPermit     = cur.userHaltPermit;
    assign haltRefused        = cur.haltRefused;
    assign traceByteCount     = cur.traceByteCount;
    assign dataTrigger        = cur.dataTrigger;
    assign hwTriggerHaltFlag  = cur.hwTriggerHaltFlag;
endmodule : dbgss_top

// file: hw/dbgss_pkg.sv
// Package with register selects, field positions, reset values and counts of the debug step block
package dbgss_pkg;
    // Debug register selects on the command port
    localparam logic [1:0] DBGSS_SEL_CTRL  = 2'h0;
    localparam logic [1:0] DBGSS_SEL_VALUE = 2'h1;
    localparam logic [1:0] DBGSS_SEL_MASK  = 2'h2;

    // Control and status field positions
    localparam int DBGSS_BIT_FLAG  = 26;
    localparam int DBGSS_BIT_UHALT = 10;
    localparam int DBGSS_BIT_BTBH = 9;
    localparam int DBGSS_BIT_BTBL = 8;
    localparam int DBGSS_BIT_NOPIPE = 6;
    localparam int DBGSS_BIT_IRQOFF = 5;
    localparam int DBGSS_BIT_STEP   = 4;

    // Reset values
    localparam logic        DBGSS_RST_BIT  = 1'h0;
    localparam logic [1:0]  DBGSS_RST_BTB  = 2'h0;
    localparam logic [31:0] DBGSS_RST_WORD = 32'h0;

    // Extra cycles added after each instruction in non-pipelined mode
    localparam logic [2:0] DBGSS_GAP_CYCLES = 3'h5;

    // Access size codes on the local bus
    localparam logic [1:0] DBGSS_SIZE_LONG = 2'h0;
    localparam logic [1:0] DBGSS_SIZE_BYTE = 2'h1;
    localparam logic [1:0] DBGSS_SIZE_WORD = 2'h2;

    // Branch target byte counts shown on the trace output
    localparam logic [2:0] DBGSS_TRACE_NONE  = 3'h0;
    localparam logic [2:0] DBGSS_TRACE_TWO   = 3'h2;
    localparam logic [2:0] DBGSS_TRACE_THREE = 3'h3;
    localparam logic [2:0] DBGSS_TRACE_FOUR  = 3'h4;

    typedef enum logic [1:0] {
        DBGSS_RUN,
        DBGSS_STEP,
        DBGSS_HALTED
    } dbgss_mode_e;
endpackage : dbgss_pkg

// file: hw/dbgss_cmp_if.sv
// Interface between the debug block and its data comparator
`timescale 1ns/1ps
interface dbgss_cmp_if;
    logic [31:0] matchValue;
    logic [31:0] matchMask;
    logic [31:0] busData;
    logic [1:0]  busAddr;
    logic [1:0]  busSize;
    logic        hit;

    modport ctrl (output matchValue, output matchMask, output busData, output busAddr, output busSize, input hit);
    modport cmp  (input matchValue, input matchMask, input busData, input busAddr, input busSize, output hit);
endinterface : dbgss_cmp_if

// file: hw/dbgss_data_cmp.sv
// Masked data comparator with byte-lane placement by address and size
`timescale 1ns/1ps
module dbgss_data_cmp
    import dbgss_pkg::*;
(
    dbgss_cmp_if.cmp cmpBus
);
    logic [3:0]  laneOn;
    logic [31:0] laneValue;
    logic [31:0] laneMask;
    logic [3:0]  laneOk;

    // Lane 3 is D[31:24], lane 0 is D[7:0]
    always_comb begin
        laneOn    = 4'hF;
        laneValue = cmpBus.matchValue;
        laneMask  = cmpBus.matchMask;
        case (cmpBus.busSize)
            DBGSS_SIZE_BYTE: begin
                laneOn    = 4'h8 >> cmpBus.busAddr;
                laneValue = {4{cmpBus.matchValue[7:0]}};
                laneMask  = {4{cmpBus.matchMask[7:0]}};
            end
            DBGSS_SIZE_WORD: begin
                laneOn    = cmpBus.busAddr[1] ? 4'h3 : 4'hC;
                laneValue = {2{cmpBus.matchValue[15:0]}};
                laneMask  = {2{cmpBus.matchMask[15:0]}};
            end
            default: begin
                laneOn    = 4'hF;
                laneValue = cmpBus.matchValue;
                laneMask  = cmpBus.matchMask;
            end
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : gLane
            // Set mask bits drop a position from the compare
            assign laneOk[gi] = !laneOn[gi] ||
                ((cmpBus.busData[gi*8 +: 8] ^ laneValue[gi*8 +: 8]) & ~laneMask[gi*8 +: 8]) == 8'h00;
        end
    endgenerate

    assign cmpBus.hit = &laneOk;
endmodule : dbgss_data_cmp

// file: verification/dbgss_checker.sv
// Concurrent checks on the ports of the debug step block
`timescale 1ns/1ps
module dbgss_checker
    import dbgss_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        cmdWrite,
    input wire logic [1:0]  cmdSel,
    input wire logic [31:0] cmdWdata,
    input wire logic        cmdGo,
    input wire logic        triggerGlobalEnable,
    input wire logic        instrRetire,
    input wire logic        pcBreakHit,
    input wire logic        busValid,
    input wire logic        issueOk,
    input wire logic        coreHalted,
    input wire logic        nonpipelinedSelect,
    input wire logic        foldDisable,
    input wire logic        irqIgnore,
    input wire logic        userHaltPermit,
    input wire logic [2:0]  traceByteCount,
    input wire logic        dataTrigger,
    input wire logic        hwTriggerHaltFlag
);
    logic ctrlWr;
    logic stepSel;
    assign ctrlWr = cmdWrite && (cmdSel == DBGSS_SEL_CTRL);
    // Shadow of the single-step bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) stepSel <= 1'b0;
        else if (ctrlWr) stepSel <= cmdWdata[DBGSS_BIT_STEP];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence halt_entry_s;
        coreHalted && hwTriggerHaltFlag && !issueOk;
    endsequence
    sequence resume_s;
        coreHalted && cmdGo;
    endsequence
    user_halt_a: assert property (ctrlWr |=> userHaltPermit == $past(cmdWdata[DBGSS_BIT_UHALT]))
        else $error("user halt permit does not follow the control write");
    trace_count_a: assert property (ctrlWr |=> traceByteCount == (($past(cmdWdata[9:8]) == 2'h0) ?
        DBGSS_TRACE_NONE : 3'($past(cmdWdata[9:8])) + 3'h1)) else $error("trace byte count wrong");
    nopipe_fold_a: assert property (foldDisable == nonpipelinedSelect)
        else $error("fold disable differs from non-pipelined select");
    nopipe_gap_a: assert property (nonpipelinedSelect && instrRetire |=> !issueOk [*5])
        else $error("issue allowed too soon after retire in non-pipelined mode");
    pc_break_a: assert property (pcBreakHit && triggerGlobalEnable && !coreHalted |=> coreHalted && !issueOk)
        else $error("pc breakpoint did not halt before issue");
    data_enable_a: assert property (dataTrigger |-> $past(busValid) && $past(triggerGlobalEnable))
        else $error("data trigger without enabled bus access");
    trigger_halt_a: assert property (dataTrigger |=> halt_entry_s)
        else $error("data trigger not followed by flagged halt");
    resume_clear_a: assert property (resume_s |=> !hwTriggerHaltFlag && !coreHalted)
        else $error("resume did not clear the trigger flag");
    irq_ignore_a: assert property (ctrlWr |=> irqIgnore == ($past(cmdWdata[5]) && $past(cmdWdata[4])))
        else $error("interrupt ignore wrong after control write");
    step_halt_a: assert property (stepSel && instrRetire && !coreHalted |=> coreHalted)
        else $error("no halt after retire in single step");
endmodule : dbgss_checker

bind dbgss_top dbgss_checker dbgss_checker_inst (.clk_sys, .rst_n, .cmdWrite, .cmdSel, .cmdWdata, .cmdGo,
    .triggerGlobalEnable, .instrRetire, .pcBreakHit, .busValid, .issueOk, .coreHalted, .nonpipelinedSelect,
    .foldDisable, .irqIgnore, .userHaltPermit, .traceByteCount, .dataTrigger, .hwTriggerHaltFlag);

// file: verification/dbgss_core_model.sv
// Behavioural core pipeline that issues instructions when allowed
`timescale 1ns/1ps
module dbgss_core_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       runCore,
    input  wire logic [3:0] retireDelay,
    input  wire logic       issueOk,
    output logic            instrStart,
    output logic            instrRetire
);
    logic       busy;
    logic       st;
    logic       rt;
    logic [3:0] count;
    initial begin
        instrStart = 1'b0;
        instrRetire = 1'b0;
        busy = 1'b0;
        count = 4'h0;
    end
    always @(posedge clk_sys) begin
        #1;
        st = 1'b0;
        rt = 1'b0;
        if (!rst_n) begin
            busy = 1'b0;
        end else if (busy) begin
            if (count == 4'h0) begin
                rt = 1'b1;
                busy = 1'b0;
            end else count = count - 4'h1;
        end else if (runCore && issueOk === 1'b1) begin
            st = 1'b1;
            busy = 1'b1;
            count = retireDelay;
        end
        instrStart = st;
        instrRetire = rt;
    end
endmodule : dbgss_core_model

// file: verification/dbgss_top_test.sv
// Self-checking testbench of the debug step block
`timescale 1ns/1ps
module dbgss_top_test
    import dbgss_pkg::*;
;
    logic        clk_sys, rst_n, cmdWrite, cmdRead, cmdGo, triggerGlobalEnable, haltExec, userMode, pcBreakHit;
    logic        busValid, runCore, instrStart, instrRetire, issueOk, coreHalted, nonpipelinedSelect, foldDisable;
    logic        irqIgnore, userHaltPermit, haltRefused, dataTrigger, hwTriggerHaltFlag;
    logic [1:0]  cmdSel, busAddr, busSize;
    logic [2:0]  traceByteCount;
    logic [3:0]  retireDelay;
    logic [31:0] cmdWdata, cmdRdata, busData;
    int          n_errors, comparisons, cycles, starts, s0;
    dbgss_top dbgss_top_inst (.clk_sys, .rst_n, .cmdWrite, .cmdRead, .cmdSel, .cmdWdata, .cmdGo, .cmdRdata,
        .triggerGlobalEnable, .instrStart, .instrRetire, .haltExec, .userMode, .pcBreakHit, .busValid, .busAddr,
        .busSize, .busData, .issueOk, .coreHalted, .nonpipelinedSelect, .foldDisable, .irqIgnore, .userHaltPermit,
        .haltRefused, .traceByteCount, .dataTrigger, .hwTriggerHaltFlag);
    dbgss_core_model dbgss_core_model_inst (.clk_sys, .rst_n, .runCore, .retireDelay, .issueOk, .instrStart,
        .instrRetire);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (instrStart === 1'b1) starts++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic wr(input logic [1:0] sel, input logic [31:0] data);
        cmdWrite = 1'b1;
        cmdSel = sel;
        cmdWdata = data;
        tick();
        cmdWrite = 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
        cmdRead = 1'b1;
        cmdSel = sel;
        tick();
        cmdRead = 1'b0;
        chk("cmdRdata", exp, cmdRdata);
        tick();
    endtask : rd
    task automatic go();
        cmdGo = 1'b1;
        tick();
        cmdGo = 1'b0;
        tick();
    endtask : go
    task automatic wait_halt();
        for (int i = 0; i < 60 && coreHalted !== 1'b1; i++) tick();
    endtask : wait_halt
    task automatic bus_case(input logic [1:0] addr, size, input logic [31:0] data, mask, input logic en, hit);
        wr(DBGSS_SEL_MASK, mask);
        triggerGlobalEnable = en;
        busValid = 1'b1;
        busAddr = addr;
        busSize = size;
        busData = data;
        tick();
        busValid = 1'b0;
        busData = ~data;
        chk("dataTrigger", hit, dataTrigger);
        tick();
        chk("hwTriggerHaltFlag", hit, hwTriggerHaltFlag);
        chk("coreHalted", hit, coreHalted);
        if (hit) rd(DBGSS_SEL_CTRL, 32'h04000000);
        if (hit) go();
        chk("hwTriggerHaltFlag", 1'b0, hwTriggerHaltFlag);
    endtask : bus_case
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        {cmdWrite, cmdRead, cmdGo, triggerGlobalEnable, haltExec, userMode, pcBreakHit, busValid, runCore} = '0;
        {cmdSel, busAddr, busSize, retireDelay, cmdWdata, busData} = '0;
        rst_n = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        tick();
        rd(DBGSS_SEL_CTRL, 32'h0);
        rd(DBGSS_SEL_VALUE, 32'h0);
        wr(DBGSS_SEL_CTRL, 32'hFFFFFFFF);
        rd(DBGSS_SEL_CTRL, 32'h00000770);
        chk("irqIgnore", 1'b1, irqIgnore);
        chk("foldDisable", 1'b1, foldDisable);
        chk("userHaltPermit", 1'b1, userHaltPermit);
        wr(2'h3, 32'hFFFFFFFF);
        rd(2'h3, 32'h0);
        wr(DBGSS_SEL_VALUE, 32'hC3D412A5);
        rd(DBGSS_SEL_VALUE, 32'hC3D412A5);
        wr(DBGSS_SEL_MASK, 32'h0F0F00FF);
        rd(DBGSS_SEL_MASK, 32'h0F0F00FF);
        for (int b = 0; b < 4; b++) begin
            wr(DBGSS_SEL_CTRL, 32'(b) << 8);
            chk("traceByteCount", (b == 0) ? 0 : b + 1, traceByteCount);
        end
        $display("test registers done");
        wr(DBGSS_SEL_CTRL, 32'h0);
        bus_case(2'h0, DBGSS_SIZE_BYTE, 32'hA55A5A5A, 32'h0, 1'b1, 1'b1);
        bus_case(2'h1, DBGSS_SIZE_BYTE, 32'h5AA55A5A, 32'h0, 1'b1, 1'b1);
        bus_case(2'h2, DBGSS_SIZE_BYTE, 32'h5A5AA55A, 32'h0, 1'b1, 1'b1);
        bus_case(2'h3, DBGSS_SIZE_BYTE, 32'h5A5A5AA5, 32'h0, 1'b1, 1'b1);
        bus_case(2'h0, DBGSS_SIZE_BYTE, 32'h5A5A5AA5, 32'h0, 1'b1, 1'b0);
        bus_case(2'h1, DBGSS_SIZE_BYTE, 32'h5A5A5A5A, 32'h000000FF, 1'b1, 1'b1);
        bus_case(2'h1, DBGSS_SIZE_WORD, 32'h12A5EDCB, 32'h0, 1'b1, 1'b1);
        bus_case(2'h3, DBGSS_SIZE_WORD, 32'hEDCB12A5, 32'h0, 1'b1, 1'b1);
        bus_case(2'h2, DBGSS_SIZE_WORD, 32'h12A5EDCB, 32'h0, 1'b1, 1'b0);
        bus_case(2'h0, DBGSS_SIZE_LONG, 32'hC3D412A5, 32'h0, 1'b1, 1'b1);
        bus_case(2'h0, DBGSS_SIZE_LONG, 32'hC3D412A4, 32'h0, 1'b1, 1'b0);
        bus_case(2'h0, DBGSS_SIZE_LONG, 32'hC3D412A4, 32'h00000001, 1'b1, 1'b1);
        bus_case(2'h0, DBGSS_SIZE_LONG, 32'hC3D412A5, 32'h0, 1'b0, 1'b0);
        $display("test data match done");
        for (int e = 0; e < 2; e++) begin
            triggerGlobalEnable = e[0];
            pcBreakHit = 1'b1;
            tick();
            pcBreakHit = 1'b0;
            chk("coreHalted", e[0], coreHalted);
            if (e == 1) go();
        end
        userMode = 1'b1;
        for (int u = 0; u < 2; u++) begin
            wr(DBGSS_SEL_CTRL, 32'(u) << 10);
            haltExec = 1'b1;
            tick();
            haltExec = 1'b0;
            chk("haltRefused", !u[0], haltRefused);
            chk("coreHalted", u[0], coreHalted);
        end
        chk("hwTriggerHaltFlag", 1'b0, hwTriggerHaltFlag);
        go();
        $display("test halt sources done");
        wr(DBGSS_SEL_CTRL, 32'h30);
        retireDelay = 4'h2;
        runCore = 1'b1;
        wait_halt();
        chk("coreHalted", 1'b1, coreHalted);
        for (int k = 0; k < 3; k++) begin
            s0 = starts;
            go();
            wait_halt();
            chk("starts", s0 + 1, starts);
        end
        wr(DBGSS_SEL_CTRL, 32'h0);
        go();
        s0 = starts;
        tick(20);
        chk("coreHalted", 1'b0, coreHalted);
        chk("running", 1'b1, starts - s0 > 4);
        $display("test single step done");
        wr(DBGSS_SEL_CTRL, 32'h40);
        retireDelay = 4'h0;
        s0 = starts;
        tick(42);
        chk("nonpipelinedSelect", 1'b1, nonpipelinedSelect);
        chk("nopipe rate", 1'b1, (starts - s0 <= 6) && (starts - s0 >= 3));
        runCore = 1'b0;
        tick(10);
        $display("test non-pipelined done");
        stop_test();
    end
endmodule : dbgss_top_test
